// *** logic/stream_regs_pkg.sv ***
// shared constants and types for the per-stream output and error-rate register bank
`default_nettype none
package stream_regs_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NUM_STREAMS = 32;
  localparam int HIZ_STREAMS = 16;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 16;
  localparam int IDX_W = 5;

  // ----------------------------------------------------------------
  // register offsets (16-bit word addresses, memory select line low)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OUTPUT_STREAM_CONTROL_OFFS = 14'h0200;
  localparam logic [ADDR_W-1:0] BER_RECEIVER_START_OFFS = 14'h0300;
  localparam logic [ADDR_W-1:0] BER_RECEIVER_LENGTH_OFFS = 14'h0320;
  localparam logic [ADDR_W-1:0] BER_ERROR_COUNT_OFFS = 14'h0360;
  localparam int MEMORY_SELECT_BIT = 13;

  // ----------------------------------------------------------------
  // output stream control field positions
  // ----------------------------------------------------------------
  localparam int RATE_LSB = 0;
  localparam int WHOLE_LSB = 4;
  localparam int FRAC_LSB = 7;
  localparam int HIZ_LSB = 9;
  localparam int CTRL_W = 12;
  localparam int START_W = 8;
  localparam int LEN_W = 9;
  localparam int COUNT_W = 16;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;
  localparam logic [START_W-1:0] START_RESET = 8'h00;
  localparam logic [LEN_W-1:0] LEN_RESET = 9'h000;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 16'hFFFF;
  localparam logic [DATA_W-1:0] RDATA_RESET = 16'h0000;

  localparam logic [3:0] RATE_OFF = 4'h0;
  localparam logic [3:0] RATE_2M = 4'h1;
  localparam logic [3:0] RATE_4M = 4'h2;
  localparam logic [3:0] RATE_8M = 4'h3;
  localparam logic [3:0] RATE_16M = 4'h4;

  typedef enum logic [1:0] {SPEED_2M, SPEED_4M, SPEED_8M, SPEED_16M} speed_e;

  // decoded per-stream settings handed to the switch datapath
  typedef struct packed {
    logic enable;
    logic hiz_force;
    speed_e speed;
    logic [4:0] adv_quarters;
    logic [2:0] hiz_adv_quarters;
    logic [START_W-1:0] ber_start;
    logic [LEN_W-1:0] ber_len;
    logic ber_active;
  } stream_cfg_s;

  localparam stream_cfg_s CFG_RESET = '0;

endpackage
`default_nettype wire

// *** logic/sat_error_counter.sv ***
// saturating bit-error counter for one input stream
`timescale 1ns/1ps
`default_nettype none

module sat_error_counter #(
  parameter int WIDTH = 16
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronised reset
  input wire logic hit, // one detected bit error
  output logic [WIDTH-1:0] count // running error total
);

  logic [WIDTH-1:0] next_count;

  always_comb begin
    next_count = count;
    if (hit && (count != {WIDTH{1'b1}})) begin // [RQ13] [RQ14]
      next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

endmodule // sat_error_counter
`default_nettype wire

// *** logic/stream_output_and_ber_regs.sv ***
// per-stream output control and error-rate receiver register bank
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RQ1: software writes zero to control bits 15..12; they read back zero.
// RQ2: hiz advance codes 0..4 give quarter steps, streams 0..15 only, 5..7 reserved.
// RQ3: at 16 Mbit/s hiz codes 0,1,2 give 0, half, one bit; others reserved.
// RQ4: fractional codes 0..3 give 0..3 quarter bits at lower rates.
// RQ5: at 16 Mbit/s fractional 00 none, 01 half bit, others reserved.
// RQ6: whole-bit advance is its binary value, 0 to 7 bits.
// RQ7: rate 0 disables stream and forces hiz high; 1..4 select rates; rest reserved.
// RQ8: one control register per output stream, 32 of them.
// RQ9: nine-bit length gives count of consecutive checked channels from start.
// RQ10: software keeps length within 32/64/128/256 per stream rate.
// RQ11: software sets length to at least one for checking to run.
// RQ12: software writes zero to length bits 15..9; they read back zero.
// RQ13: per-stream 16-bit error count, readable, not writable.
// RQ14: error count holds at all ones and never wraps.
// RQ15: eight-bit start field picks first checked channel; upper bits reserved.
// RQ16: host holds the top address line low to reach these registers.
module stream_output_and_ber_regs (
  input wire logic CLK, // system clock, 40 MHz
  input wire logic RST_B, // asynchronous reset, active low
  input wire logic HOST_ACC, // one-cycle access strobe
  input wire logic HOST_WR, // write when high, read when low
  input wire logic [13:0] HOST_ADDR, // word address, bit 13 selects memories
  input wire logic [15:0] HOST_WDATA, // write data
  output logic [15:0] HOST_RDATA, // registered read data
  output logic HOST_RVALID, // read data valid pulse
  input wire logic [31:0] BER_ERR_HIT, // per-stream bit error pulses
  output stream_regs_pkg::stream_cfg_s STREAM_CFG [32] // decoded stream settings
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync;
  logic rst_n;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic reg_space;
  logic [4:0] idx;
  logic [7:0] page;
  logic hit_ctrl;
  logic hit_start;
  logic hit_len;
  logic hit_count;
  logic wr_go;
  logic rd_go;

  assign reg_space = !HOST_ADDR[stream_regs_pkg::MEMORY_SELECT_BIT]; // [RQ16]
  assign idx = HOST_ADDR[4:0]; // [RQ8]
  assign page = HOST_ADDR[12:5];
  assign hit_ctrl = page == stream_regs_pkg::OUTPUT_STREAM_CONTROL_OFFS[12:5];
  assign hit_start = page == stream_regs_pkg::BER_RECEIVER_START_OFFS[12:5];
  assign hit_len = page == stream_regs_pkg::BER_RECEIVER_LENGTH_OFFS[12:5];
  assign hit_count = page == stream_regs_pkg::BER_ERROR_COUNT_OFFS[12:5];
  assign wr_go = HOST_ACC && HOST_WR && reg_space;
  assign rd_go = HOST_ACC && !HOST_WR && reg_space;

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [11:0] ctrl [32];
  logic [7:0] start [32];
  logic [8:0] len [32];
  logic [11:0] next_ctrl [32];
  logic [7:0] next_start [32];
  logic [8:0] next_len [32];

  always_comb begin
    for (int i = 0; i < 32; i++) begin
      next_ctrl[i] = ctrl[i];
      next_start[i] = start[i];
      next_len[i] = len[i];
    end
    // reserved upper bits are simply not stored
    if (wr_go && hit_ctrl) begin
      next_ctrl[idx] = HOST_WDATA[11:0]; // [RQ1] [RQ8]
    end
    if (wr_go && hit_start) begin
      next_start[idx] = HOST_WDATA[7:0]; // [RQ15]
    end
    if (wr_go && hit_len) begin
      next_len[idx] = HOST_WDATA[8:0]; // [RQ9] [RQ12]
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 32; i++) begin
        ctrl[i] <= stream_regs_pkg::CTRL_RESET;
        start[i] <= stream_regs_pkg::START_RESET;
        len[i] <= stream_regs_pkg::LEN_RESET;
      end
    end else begin
      for (int i = 0; i < 32; i++) begin
        ctrl[i] <= next_ctrl[i];
        start[i] <= next_start[i];
        len[i] <= next_len[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // error counters
  // ----------------------------------------------------------------
  logic [15:0] err_count [32];

  generate
    for (genvar g = 0; g < 32; g++) begin : g_cnt
      sat_error_counter #(
        .WIDTH(stream_regs_pkg::COUNT_W)
      ) u_cnt (
        .clk(CLK),
        .rst_n(rst_n),
        .hit(BER_ERR_HIT[g]), // [RQ13] [RQ14]
        .count(err_count[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [15:0] next_rdata;
  logic next_rvalid;

  always_comb begin
    next_rdata = stream_regs_pkg::RDATA_RESET;
    next_rvalid = rd_go;
    if (rd_go) begin
      if (hit_ctrl) begin
        next_rdata = {4'h0, ctrl[idx]}; // [RQ1]
      end else if (hit_start) begin
        next_rdata = {8'h00, start[idx]}; // [RQ15]
      end else if (hit_len) begin
        next_rdata = {7'h00, len[idx]}; // [RQ12]
      end else if (hit_count) begin
        next_rdata = err_count[idx]; // [RQ13]
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      HOST_RDATA <= stream_regs_pkg::RDATA_RESET;
      HOST_RVALID <= 1'b0;
    end else begin
      HOST_RDATA <= next_rdata;
      HOST_RVALID <= next_rvalid;
    end
  end

  // ----------------------------------------------------------------
  // per-stream decode for the datapath
  // ----------------------------------------------------------------
  stream_regs_pkg::stream_cfg_s next_cfg [32];

  always_comb begin
    logic [3:0] rate;
    logic [2:0] whole;
    logic [1:0] frac;
    logic [2:0] hiz;
    rate = 4'h0;
    whole = 3'h0;
    frac = 2'h0;
    hiz = 3'h0;
    for (int i = 0; i < 32; i++) begin
      rate = ctrl[i][stream_regs_pkg::RATE_LSB +: 4];
      whole = ctrl[i][stream_regs_pkg::WHOLE_LSB +: 3];
      frac = ctrl[i][stream_regs_pkg::FRAC_LSB +: 2];
      hiz = ctrl[i][stream_regs_pkg::HIZ_LSB +: 3];
      next_cfg[i] = stream_regs_pkg::CFG_RESET;
      next_cfg[i].ber_start = start[i]; // [RQ15]
      next_cfg[i].ber_len = len[i]; // [RQ9]
      next_cfg[i].ber_active = len[i] != 9'h000; // [RQ11]
      // reserved rate codes are treated as off so the pin stays quiet
      next_cfg[i].enable = (rate >= stream_regs_pkg::RATE_2M)
                           && (rate <= stream_regs_pkg::RATE_16M); // [RQ7]
      next_cfg[i].hiz_force = !next_cfg[i].enable; // [RQ7]
      unique case (rate)
        stream_regs_pkg::RATE_4M: next_cfg[i].speed = stream_regs_pkg::SPEED_4M;
        stream_regs_pkg::RATE_8M: next_cfg[i].speed = stream_regs_pkg::SPEED_8M;
        stream_regs_pkg::RATE_16M: next_cfg[i].speed = stream_regs_pkg::SPEED_16M;
        default: next_cfg[i].speed = stream_regs_pkg::SPEED_2M;
      endcase
      if (rate == stream_regs_pkg::RATE_16M) begin
        // reserved codes fall back to no advance
        next_cfg[i].adv_quarters = {whole, (frac == 2'h1) ? 2'h2 : 2'h0}; // [RQ5] [RQ6]
        if (hiz <= 3'h2) begin
          next_cfg[i].hiz_adv_quarters = {hiz[1:0], 1'b0}; // [RQ3]
        end
      end else begin
        next_cfg[i].adv_quarters = {whole, frac}; // [RQ4] [RQ6]
        if (hiz <= 3'h4) begin
          next_cfg[i].hiz_adv_quarters = hiz; // [RQ2]
        end
      end
      if (i >= stream_regs_pkg::HIZ_STREAMS) begin
        next_cfg[i].hiz_adv_quarters = 3'h0; // [RQ2]
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 32; i++) begin
        STREAM_CFG[i] <= stream_regs_pkg::CFG_RESET;
      end
    end else begin
      for (int i = 0; i < 32; i++) begin
        STREAM_CFG[i] <= next_cfg[i];
      end
    end
  end

endmodule // stream_output_and_ber_regs
`default_nettype wire

// *** tb/stream_regs_assertions.sv ***
// port checker for the stream register bank
`timescale 1ns/1ps
`default_nettype none
module stream_regs_checker (
  input wire logic CLK, // clock
  input wire logic RST_B, // reset
  input wire logic HOST_ACC, // strobe
  input wire logic HOST_WR, // write
  input wire logic [13:0] HOST_ADDR, // address
  input wire logic [15:0] HOST_WDATA, // wdata
  input wire logic [15:0] HOST_RDATA, // rdata
  input wire logic HOST_RVALID, // rvalid
  input wire logic [31:0] BER_ERR_HIT, // hits
  input wire stream_regs_pkg::stream_cfg_s STREAM_CFG [32] // settings
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  wire logic rd_take = HOST_ACC && !HOST_WR && !HOST_ADDR[13];
  a_read_answer: assert property (rd_take |=> HOST_RVALID)
    else $error("read not answered");
  a_no_stray_rvalid: assert property (!rd_take |=> !HOST_RVALID)
    else $error("rvalid without read");
  a_rdata_idle: assert property (!HOST_RVALID |-> HOST_RDATA == 16'h0000)
    else $error("rdata not zero when idle");
  a_ctrl_top_zero: assert property (HOST_RVALID && $past(HOST_ADDR[13:5]) == 9'h010
    |-> HOST_RDATA[15:12] == 4'h0)
    else $error("control reserved bits set");
  a_start_top_zero: assert property (HOST_RVALID && $past(HOST_ADDR[13:5]) == 9'h018
    |-> HOST_RDATA[15:8] == 8'h00)
    else $error("start reserved bits set");
  a_len_top_zero: assert property (HOST_RVALID && $past(HOST_ADDR[13:5]) == 9'h019
    |-> HOST_RDATA[15:9] == 7'h00)
    else $error("length reserved bits set");
  a_enabled_no_hiz: assert property (HOST_ACC && HOST_WR && HOST_ADDR == 14'h021F
    |-> ##2 STREAM_CFG[31].enable == ($past(HOST_WDATA[3:0], 2) inside {[4'h1:4'h4]})
    && STREAM_CFG[31].hiz_force == !STREAM_CFG[31].enable)
    else $error("stream 31 enable decode wrong");
  a_upper_no_hiz: assert property (STREAM_CFG[20].hiz_adv_quarters == 3'h0)
    else $error("hiz advance on upper stream");
  a_fast_half_steps: assert property (STREAM_CFG[5].speed == stream_regs_pkg::SPEED_16M
    |-> !STREAM_CFG[5].adv_quarters[0] && !STREAM_CFG[5].hiz_adv_quarters[0])
    else $error("odd quarter at top rate");
  a_ber_active_len: assert property (HOST_ACC && HOST_WR && HOST_ADDR == 14'h0327
    |-> ##2 STREAM_CFG[7].ber_len == $past(HOST_WDATA[8:0], 2)
    && STREAM_CFG[7].ber_active == ($past(HOST_WDATA[8:0], 2) != 9'h000))
    else $error("receiver length decode wrong");
  cover property (HOST_RVALID);
  cover property (STREAM_CFG[7].ber_active);
  cover property (STREAM_CFG[5].speed == stream_regs_pkg::SPEED_16M);
endmodule // stream_regs_checker
bind stream_output_and_ber_regs stream_regs_checker stream_regs_checker_inst (
  .CLK(CLK), .RST_B(RST_B), .HOST_ACC(HOST_ACC), .HOST_WR(HOST_WR), .HOST_ADDR(HOST_ADDR),
  .HOST_WDATA(HOST_WDATA), .HOST_RDATA(HOST_RDATA), .HOST_RVALID(HOST_RVALID),
  .BER_ERR_HIT(BER_ERR_HIT), .STREAM_CFG(STREAM_CFG));
`default_nettype wire

// *** tb/host_port_model.sv ***
// host processor model driving the register port
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
  input wire logic clk, // clock
  output logic acc, // strobe
  output logic wr_en, // write
  output logic [13:0] addr, // address
  output logic [15:0] wdata, // wdata
  input wire logic [15:0] rdata, // rdata
  input wire logic rvalid // rvalid
);
  initial begin
    acc = 1'b0;
    wr_en = 1'b0;
    addr = 14'h3FFF;
    wdata = 16'h0000;
  end
  task automatic put(input logic w, input logic [12:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    acc = 1'b1;
    wr_en = w;
    addr = {1'b0, a};
    wdata = d;
    @(posedge clk);
    #1;
    acc = 1'b0;
    // released lines show junk, not the last value
    addr = {1'b1, ~a};
    wdata = ~d;
  endtask
  task automatic wr(input logic [12:0] a, input logic [15:0] d);
    put(1'b1, a, d);
  endtask
  task automatic rd(input logic [12:0] a, output logic [15:0] d, output logic ok);
    ok = 1'b0;
    d = 16'h0000;
    put(1'b0, a, 16'h0000);
    for (int i = 0; i < 4 && !ok; i++) begin
      if (rvalid === 1'b1) begin
        ok = 1'b1;
        d = rdata;
      end else begin
        @(posedge clk);
        #1;
      end
    end
  endtask
endmodule // host_port_model
`default_nettype wire

// *** tb/stream_output_and_ber_regs_tb.sv ***
// self-checking bench for the stream register bank
`timescale 1ns/1ps
`default_nettype none
module stream_output_and_ber_regs_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic host_acc, host_wr, host_rvalid;
  logic [13:0] host_addr;
  logic [15:0] host_wdata, host_rdata;
  logic [31:0] err_hit = 32'h0000_0000;
  stream_regs_pkg::stream_cfg_s cfg [32];
  int miscompares = 0;
  int n_tests = 0;
  always #12.5 clk = ~clk;
  host_port_model host_port_model_inst (.clk(clk), .acc(host_acc), .wr_en(host_wr),
    .addr(host_addr), .wdata(host_wdata), .rdata(host_rdata), .rvalid(host_rvalid));
  stream_output_and_ber_regs stream_output_and_ber_regs_inst (.CLK(clk), .RST_B(rst_b),
    .HOST_ACC(host_acc), .HOST_WR(host_wr), .HOST_ADDR(host_addr), .HOST_WDATA(host_wdata),
    .HOST_RDATA(host_rdata), .HOST_RVALID(host_rvalid), .BER_ERR_HIT(err_hit),
    .STREAM_CFG(cfg));
  task automatic end_sim;
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd(input logic [12:0] a, input logic [15:0] exp, input string what);
    logic [15:0] d;
    logic ok;
    host_port_model_inst.rd(a, d, ok);
    if (ok !== 1'b1) begin
      miscompares++;
      end_sim();
    end else begin
      chk(what, d, exp);
    end
  endtask
  task automatic reset_values;
    rd(13'h0200, 16'h0000, "ctrl0");
    rd(13'h031F, 16'h0000, "start31");
    rd(13'h0365, 16'h0000, "count5");
    rd(13'h0100, 16'h0000, "unmapped");
  endtask
  task automatic low_rate;
    // top nibble written zero, as software must
    host_port_model_inst.wr(13'h0203, 16'h0973);
    rd(13'h0203, 16'h0973, "ctrl3");
    chk("speed3", 16'(cfg[3].speed), 16'(stream_regs_pkg::SPEED_8M));
    chk("adv3", 16'(cfg[3].adv_quarters), 16'h001E);
    chk("hizadv3", 16'(cfg[3].hiz_adv_quarters), 16'h0004);
  endtask
  task automatic top_rate;
    host_port_model_inst.wr(13'h0205, 16'h0484);
    host_port_model_inst.wr(13'h0214, 16'h0484);
    // reserved hiz code 6 with fraction 11 at the lowest rate
    host_port_model_inst.wr(13'h0206, 16'h0D81);
    rd(13'h0214, 16'h0484, "ctrl20");
    chk("adv5", 16'(cfg[5].adv_quarters), 16'h0002);
    chk("hizadv5", 16'(cfg[5].hiz_adv_quarters), 16'h0004);
    chk("hizadv20", 16'(cfg[20].hiz_adv_quarters), 16'h0000);
    chk("adv6", 16'(cfg[6].adv_quarters), 16'h0003);
    chk("hizadv6", 16'(cfg[6].hiz_adv_quarters), 16'h0000);
  endtask
  task automatic rate_codes;
    for (int c = 0; c < 6; c++) begin
      host_port_model_inst.wr(13'h021F, 16'(c));
      rd(13'h021F, 16'(c), "rate31");
      chk("en31", 16'(cfg[31].enable), 16'(c >= 1 && c <= 4));
      chk("hiz31", 16'(cfg[31].hiz_force), 16'(c == 0 || c == 5));
      chk("spd31", 16'(cfg[31].speed), 16'((c >= 1 && c <= 4) ? c - 1 : 0));
    end
  endtask
  task automatic ber_setup;
    // top rate with reserved fraction code 10
    host_port_model_inst.wr(13'h0207, 16'h0104);
    host_port_model_inst.wr(13'h0307, 16'h00A5);
    host_port_model_inst.wr(13'h0327, 16'h0100);
    rd(13'h0307, 16'h00A5, "start7");
    rd(13'h0327, 16'h0100, "len7");
    chk("bstart7", 16'(cfg[7].ber_start), 16'h00A5);
    chk("blen7", 16'(cfg[7].ber_len), 16'h0100);
    chk("bact7", 16'(cfg[7].ber_active), 16'h0001);
    chk("adv7", 16'(cfg[7].adv_quarters), 16'h0000);
  endtask
  task automatic error_counts;
    @(posedge clk);
    #1;
    err_hit = 32'h0000_0004;
    repeat (3) @(posedge clk);
    #1;
    err_hit = 32'h0000_0000;
    rd(13'h0362, 16'h0003, "count2");
    host_port_model_inst.wr(13'h0362, 16'h1234);
    rd(13'h0362, 16'h0003, "count2ro");
    err_hit = 32'hFFFF_FFFF;
    // long enough to pass the all-ones limit
    repeat (65540) @(posedge clk);
    #1;
    rd(13'h0369, 16'hFFFF, "count9sat");
    rd(13'h0362, 16'hFFFF, "count2sat");
  endtask
  task automatic mid_reset;
    err_hit = 32'h0000_0000;
    @(posedge clk);
    #1;
    rst_b = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_b = 1'b1;
    // internal copy needs two edges before the first access
    repeat (3) @(posedge clk);
    #1;
    chk("bact7rst", 16'(cfg[7].ber_active), 16'h0000);
    chk("adv3rst", 16'(cfg[3].adv_quarters), 16'h0000);
    rd(13'h0369, 16'h0000, "count9rst");
    rd(13'h0203, 16'h0000, "ctrl3rst");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst_b = 1'b1;
    repeat (3) @(posedge clk);
    reset_values();
    low_rate();
    top_rate();
    rate_codes();
    ber_setup();
    error_counts();
    mid_reset();
    end_sim();
  end
endmodule // stream_output_and_ber_regs_tb
`default_nettype wire
